/* verilog/aca_consts.svh */
// Constants for the asynchronous adapter instruction control: offsets, fields, codes and timing.
`ifndef ACA_CONSTS_SVH
`define ACA_CONSTS_SVH
`define CLK_KHZ          64'd125000
`define CLK_HZ           32'd125000000
`define LONG_TIMEOUT_MS  64'd14000
`define LONG_TIMEOUT_CYC (`LONG_TIMEOUT_MS * `CLK_KHZ)
`define REV_DROP_MS      64'd500
`define REV_DROP_CYC     (`REV_DROP_MS * `CLK_KHZ)
`define REG_CTRL         8'h00
`define REG_INFO         8'h04
`define REG_STATION      8'h08
`define CTRL_IO_RESET    0
`define INIT_COUNT       3'h3
`define DIAL_COUNT       3'h1
`define HANGUP_COUNT     3'h2
`define REV_OFF_MIN      3'h5
`define INIT_ARC_BIT     6
`define INIT_EVEN_BIT    4
`define INIT_SF_BIT      3
`define ST_FIXED         7'h20
`define ST_FAULT_BIT     2
`define ST_FLAG_BIT      1
`define ST_ERROR_BIT     0
`define TSC_END_BIT      2
`define TSC_PAR_BIT      3
`define CODE_ETX         7'h03
`define CODE_EOT         7'h04
`define CODE_ENQ         7'h05
`define CODE_ACK         7'h06
`define CODE_DLE         7'h10
`define CODE_NAK         7'h15
`define CODE_ETB         7'h17
`define CTRL_CODE_MASK   7'h3F
`define RATE_150         32'd150
`define RATE_300         32'd300
`define RATE_600         32'd600
`define RATE_1200        32'd1200
`define RATE_1800        32'd1800
`endif

/* verilog/aca_pkg.sv */
// Types shared by the adapter instruction control.
package aca_pkg;
	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_INIT   = 8'h02,
		ST_CTRLTX = 8'h04,
		ST_HUNT   = 8'h08,
		ST_RECV   = 8'h10,
		ST_WRITE  = 8'h20,
		ST_DIAL   = 8'h40,
		ST_DONE   = 8'h80
	} ctl_state_e;
	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_RDCTL = 2'h2,
		OP_WRCTL = 2'h3
	} op_e;
endpackage : aca_pkg

/* verilog/aca_instr_ctrl.sv */
// Instruction control of the asynchronous serial communications adapter with an APB register port.
`timescale 1ns/100ps
`include "aca_consts.svh"

module aca_instr_ctrl #(
	parameter logic [31:0] TIMEOUT_CYC = 32'(`LONG_TIMEOUT_CYC), // Inactivity timeout in cycles.
	parameter logic [31:0] REVDROP_CYC = 32'(`REV_DROP_CYC)      // Reverse-channel drop length.
) (
	input  wire logic        pclk,               // Clock, 125 MHz.
	input  wire logic        presetn,            // Asynchronous reset, active low.
	input  wire logic        psel,               // APB select.
	input  wire logic        penable,            // APB enable.
	input  wire logic        pwrite,             // APB direction.
	input  wire logic [7:0]  paddr,              // APB byte address.
	input  wire logic [31:0] pwdata,             // APB write data.
	output logic             pready,             // APB ready.
	output logic      [31:0] prdata,             // APB read data.
	output logic             pslverr,            // APB error on unmapped address.
	input  wire logic        instr_valid,        // Select character strobe.
	input  wire logic [6:0]  instr_char,         // Select character bits 7..1.
	input  wire logic        mem_valid,          // Character from memory strobe.
	input  wire logic [6:0]  mem_char,           // Character from memory.
	input  wire logic        last_char_flag,     // Processor count exhausted.
	output logic             output_request,     // Adapter wants memory characters.
	output logic             mem_wr_valid,       // Character to memory strobe.
	output logic      [6:0]  mem_wr_char,        // Character to memory.
	output logic             io_busy_flag,       // Instruction in progress.
	output logic             status_valid,       // Status character strobe.
	output logic      [6:0]  status_char,        // Status character bits 7..1.
	output logic             tx_valid,           // Character to serializer strobe.
	output logic      [6:0]  tx_char,            // Character to serializer.
	input  wire logic        tx_ready,           // Serializer can take a character.
	input  wire logic        rx_valid,           // Received character strobe.
	input  wire logic [6:0]  rx_char,            // Received character.
	input  wire logic        rx_error,           // Framing or parity error on it.
	output logic             bit_tick,           // One pulse per bit time.
	output logic             even_parity,        // Parity sense for the serializer.
	output logic             store_forward_mode, // Store-forward mode selected.
	input  wire logic        modem_ready,        // Data set ready pin.
	input  wire logic        carrier_on,         // Carrier detect pin.
	input  wire logic        dialer_active,      // Dial card busy pin.
	input  wire logic        abandon_call_retry, // Calling unit gave up pin.
	output logic             reverse_channel,    // Reverse-channel signal.
	output logic             dial_start,         // Start dialing pulse.
	output logic             hang_up             // Disconnect pulse.
);
	// Pin synchronisers, two flops each.
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic       carrier_prev_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_q     <= 4'h0;
			pin_sync_q     <= 4'h0;
			carrier_prev_q <= 1'b0;
		end else begin
			pin_meta_q     <= {abandon_call_retry, dialer_active, carrier_on, modem_ready};
			pin_sync_q     <= pin_meta_q;
			carrier_prev_q <= pin_sync_q[1];
		end
	end
	logic modem_ok, dialing, abandon, carrier_drop;
	assign modem_ok     = pin_sync_q[0];
	assign dialing      = pin_sync_q[2];
	assign abandon      = pin_sync_q[3];
	assign carrier_drop = carrier_prev_q & ~pin_sync_q[1];

	// Divider value for a rate code; unused codes give no tick.
	function automatic logic [31:0] rate_div(input logic [2:0] code);
		unique case (code)
			3'h1:    rate_div = `CLK_HZ / `RATE_150;
			3'h2:    rate_div = `CLK_HZ / `RATE_300;
			3'h3:    rate_div = `CLK_HZ / `RATE_600;
			3'h4:    rate_div = `CLK_HZ / `RATE_1200;
			3'h5:    rate_div = `CLK_HZ / `RATE_1800;
			default: rate_div = 32'h0;
		endcase
	endfunction : rate_div

	// True for the ASCII codes that end a normal read.
	function automatic logic is_end_code(input logic [6:0] c);
		is_end_code = (c == `CODE_ETB) || (c == `CODE_ETX) || (c == `CODE_ENQ) ||
			(c == `CODE_ACK) || (c == `CODE_NAK) || (c == `CODE_EOT);
	endfunction : is_end_code

	// APB slave with one wait state; writes to the control word with bit 0 set act as an I/O reset.
	logic io_reset_req;
	assign io_reset_req = psel && penable && pwrite && !pready && (paddr == `REG_CTRL) &&
		pwdata[`CTRL_IO_RESET];

	aca_pkg::ctl_state_e state_q;
	logic        init_done_q;
	logic [6:0]  init_char_q;
	logic [6:0]  station_id_q;
	logic [6:0]  last_status_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (psel && penable && !pready) begin
				unique case (paddr)
					`REG_CTRL:    prdata <= 32'h0;
					`REG_INFO:    prdata <= {16'h0, state_q, init_done_q, init_char_q};
					`REG_STATION: prdata <= {17'h0, last_status_q, 1'b0, station_id_q};
					default:      pslverr <= 1'b1;
				endcase
			end
		end
	end

	// Initialization parameters, kept until a new init or a reset.
	logic init_take;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_done_q <= 1'b0;
			init_char_q <= 7'h0;
		end else if (init_take) begin
			init_done_q <= 1'b1;
			init_char_q <= mem_char;
		end else if (io_reset_req) begin
			init_done_q <= 1'b0;
			init_char_q <= 7'h0;
		end
	end
	assign even_parity        = init_char_q[`INIT_EVEN_BIT];
	assign store_forward_mode = init_char_q[`INIT_SF_BIT];

	// Bit-rate divider producing the bit enable.
	logic [31:0] rate_cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_cnt_q <= 32'h0;
			bit_tick   <= 1'b0;
		end else begin
			bit_tick <= 1'b0;
			if (rate_div(init_char_q[2:0]) == 32'h0 || !init_done_q) begin
				rate_cnt_q <= 32'h0;
			end else if (rate_cnt_q >= rate_div(init_char_q[2:0]) - 32'h1) begin
				rate_cnt_q <= 32'h0;
				bit_tick   <= 1'b1;
			end else begin
				rate_cnt_q <= rate_cnt_q + 32'h1;
			end
		end
	end

	// Reverse channel: timed drop after carrier loss, or held off by write-control.
	logic [31:0] rev_cnt_q;
	logic        rev_hold_q;
	logic        rev_off_req;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rev_cnt_q  <= 32'h0;
			rev_hold_q <= 1'b0;
		end else begin
			if (carrier_drop && init_done_q && init_char_q[`INIT_ARC_BIT]) begin
				rev_cnt_q <= REVDROP_CYC;
			end else if (rev_cnt_q != 32'h0) begin
				rev_cnt_q <= rev_cnt_q - 32'h1;
			end
			if (rev_off_req) begin
				rev_hold_q <= 1'b1;
			end else if (instr_valid && !dialing && state_q == aca_pkg::ST_IDLE) begin
				rev_hold_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reverse_channel <= 1'b0;
		end else begin
			reverse_channel <= init_done_q && !rev_hold_q && (rev_cnt_q == 32'h0);
		end
	end

	// Instruction sequencer.
	aca_pkg::op_e op_q;
	logic [2:0] cnt_q;
	logic       ctrl_ff_q;
	logic       dle_seen_q, end_seen_q;
	logic       fault_q, flag_q, error_q, par_err_q;
	logic       tsc_pending_q;
	logic [31:0] idle_cnt_q;
	logic       timed_out;
	logic       xfer_mem;
	logic       op_active;
	aca_pkg::op_e new_op;

	assign new_op    = aca_pkg::op_e'(instr_char[5:4]);
	assign op_active = (state_q == aca_pkg::ST_CTRLTX) || (state_q == aca_pkg::ST_HUNT) ||
		(state_q == aca_pkg::ST_RECV) || (state_q == aca_pkg::ST_WRITE);
	assign timed_out = op_active && (idle_cnt_q >= TIMEOUT_CYC - 32'h1);
	assign xfer_mem  = (output_request && mem_valid) || mem_wr_valid;
	assign init_take = (state_q == aca_pkg::ST_INIT) && output_request && mem_valid;
	assign rev_off_req = (state_q == aca_pkg::ST_IDLE) && instr_valid && !dialing && init_done_q &&
		(new_op == aca_pkg::OP_WRCTL) && (instr_char[2:0] >= `REV_OFF_MIN);

	// Inactivity timer, suspended during a reverse-channel drop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt_q <= 32'h0;
		end else if (!op_active || xfer_mem || rx_valid) begin
			idle_cnt_q <= 32'h0;
		end else if (rev_cnt_q == 32'h0) begin
			idle_cnt_q <= idle_cnt_q + 32'h1;
		end
	end

	// Main control flow.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q        <= aca_pkg::ST_IDLE;
			op_q           <= aca_pkg::OP_READ;
			cnt_q          <= 3'h0;
			ctrl_ff_q      <= 1'b0;
			dle_seen_q     <= 1'b0;
			end_seen_q     <= 1'b0;
			fault_q        <= 1'b0;
			flag_q         <= 1'b0;
			error_q        <= 1'b0;
			par_err_q      <= 1'b0;
			tsc_pending_q  <= 1'b0;
			station_id_q   <= 7'h0;
			last_status_q  <= 7'h0;
			output_request <= 1'b0;
			mem_wr_valid   <= 1'b0;
			mem_wr_char    <= 7'h0;
			io_busy_flag   <= 1'b0;
			status_valid   <= 1'b0;
			status_char    <= 7'h0;
			tx_valid       <= 1'b0;
			tx_char        <= 7'h0;
			dial_start     <= 1'b0;
			hang_up        <= 1'b0;
		end else begin
			mem_wr_valid <= 1'b0;
			status_valid <= 1'b0;
			tx_valid     <= 1'b0;
			dial_start   <= 1'b0;
			hang_up      <= 1'b0;
			if (rx_valid && rx_error && (state_q == aca_pkg::ST_RECV)) begin
				error_q   <= 1'b1;
				par_err_q <= 1'b1;
			end
			unique case (state_q)
				aca_pkg::ST_IDLE: begin
					if (instr_valid && !dialing) begin
						op_q         <= new_op;
						cnt_q        <= instr_char[2:0];
						ctrl_ff_q    <= (new_op == aca_pkg::OP_RDCTL);
						dle_seen_q   <= 1'b0;
						end_seen_q   <= 1'b0;
						{fault_q, flag_q, error_q, par_err_q} <= 4'h0;
						io_busy_flag <= 1'b1;
						state_q      <= aca_pkg::ST_DONE;
						if (new_op == aca_pkg::OP_WRCTL && instr_char[2:0] == `INIT_COUNT) begin
							output_request <= 1'b1;
							state_q        <= aca_pkg::ST_INIT;
						end else if (!init_done_q) begin
							flag_q <= 1'b1;
						end else if (new_op == aca_pkg::OP_WRCTL) begin
							if (instr_char[2:0] == `DIAL_COUNT) begin
								dial_start <= 1'b1;
								state_q    <= aca_pkg::ST_DIAL;
							end
							hang_up <= (instr_char[2:0] == `HANGUP_COUNT);
						end else if (instr_char[2:0] != 3'h0) begin
							output_request <= 1'b1;
							state_q        <= aca_pkg::ST_CTRLTX;
						end else if (new_op == aca_pkg::OP_WRITE) begin
							output_request <= 1'b1;
							state_q        <= aca_pkg::ST_WRITE;
						end else if (new_op == aca_pkg::OP_RDCTL) begin
							state_q <= aca_pkg::ST_HUNT;
						end else begin
							state_q <= aca_pkg::ST_RECV;
						end
					end
				end
				aca_pkg::ST_INIT: begin
					if (mem_valid) begin
						output_request <= 1'b0;
						state_q        <= aca_pkg::ST_DONE;
					end
				end
				aca_pkg::ST_CTRLTX: begin
					if (timed_out || !modem_ok) begin
						fault_q        <= 1'b1;
						output_request <= 1'b0;
						state_q        <= aca_pkg::ST_DONE;
					end else if (mem_valid && tx_ready) begin
						if (ctrl_ff_q) begin
							station_id_q <= mem_char;
							ctrl_ff_q    <= 1'b0;
						end else begin
							tx_valid <= 1'b1;
							tx_char  <= mem_char & `CTRL_CODE_MASK;
						end
						cnt_q <= cnt_q - 3'h1;
						if (cnt_q == 3'h1) begin
							if (op_q == aca_pkg::OP_WRITE) begin
								state_q <= aca_pkg::ST_WRITE;
							end else begin
								output_request <= 1'b0;
								state_q <= (op_q == aca_pkg::OP_RDCTL) ? aca_pkg::ST_HUNT : aca_pkg::ST_RECV;
							end
						end
					end
				end
				aca_pkg::ST_WRITE: begin
					if (timed_out || !modem_ok) begin
						fault_q        <= 1'b1;
						output_request <= 1'b0;
						state_q        <= aca_pkg::ST_DONE;
					end else if (mem_valid && tx_ready) begin
						tx_valid <= 1'b1;
						tx_char  <= mem_char;
					end else if (last_char_flag) begin
						output_request <= 1'b0;
						state_q        <= aca_pkg::ST_DONE;
					end
				end
				aca_pkg::ST_HUNT: begin
					if (timed_out) begin
						fault_q <= 1'b1;
						state_q <= aca_pkg::ST_DONE;
					end else if (rx_valid && !ctrl_ff_q && rx_char == station_id_q) begin
						mem_wr_valid <= 1'b1;
						mem_wr_char  <= rx_char;
						state_q      <= aca_pkg::ST_RECV;
					end
				end
				aca_pkg::ST_RECV: begin
					if (timed_out) begin
						fault_q <= 1'b1;
						state_q <= aca_pkg::ST_DONE;
					end else if (rx_valid) begin
						mem_wr_valid <= 1'b1;
						mem_wr_char  <= rx_char;
						dle_seen_q   <= (rx_char == `CODE_DLE) && !dle_seen_q;
						if (dle_seen_q || is_end_code(rx_char)) begin
							end_seen_q <= 1'b1;
							state_q    <= aca_pkg::ST_DONE;
						end
					end else if (last_char_flag) begin
						flag_q  <= 1'b1;
						state_q <= aca_pkg::ST_DONE;
					end
				end
				aca_pkg::ST_DIAL: begin
					if (abandon) begin
						error_q <= 1'b1;
						state_q <= aca_pkg::ST_DONE;
					end else if (last_char_flag) begin
						state_q <= aca_pkg::ST_DONE;
					end
				end
				aca_pkg::ST_DONE: begin
					if (error_q && !flag_q && store_forward_mode && !tsc_pending_q) begin
						tsc_pending_q <= 1'b1;
						mem_wr_valid  <= 1'b1;
						mem_wr_char   <= (7'h01 << `TSC_END_BIT) & {7{end_seen_q}} |
							(7'h01 << `TSC_PAR_BIT) & {7{par_err_q}};
					end else begin
						tsc_pending_q <= 1'b0;
						io_busy_flag  <= 1'b0;
						status_valid  <= 1'b1;
						if (flag_q) begin
							status_char   <= `ST_FIXED | (7'h01 << `ST_FLAG_BIT);
							last_status_q <= `ST_FIXED | (7'h01 << `ST_FLAG_BIT);
						end else begin
							status_char   <= `ST_FIXED | (7'(fault_q) << `ST_FAULT_BIT) |
								(7'(error_q) << `ST_ERROR_BIT);
							last_status_q <= `ST_FIXED | (7'(fault_q) << `ST_FAULT_BIT) |
								(7'(error_q) << `ST_ERROR_BIT);
						end
						state_q <= aca_pkg::ST_IDLE;
					end
				end
				default: state_q <= aca_pkg::ST_IDLE;
			endcase
		end
	end
endmodule : aca_instr_ctrl

/* verification/instr_ctrl_props.sv */
// Checker for the adapter instruction control, bound to its ports.
`timescale 1ns/100ps
module instr_ctrl_checker (
	input wire logic       pclk,           // Clock.
	input wire logic       presetn,        // Reset, active low.
	input wire logic       instr_valid,    // Select strobe.
	input wire logic [6:0] instr_char,     // Select character.
	input wire logic       mem_valid,      // Memory character strobe.
	input wire logic       output_request, // Adapter wants characters.
	input wire logic       io_busy_flag,   // Instruction active.
	input wire logic       status_valid,   // Status strobe.
	input wire logic [6:0] status_char,    // Status character.
	input wire logic       tx_valid,       // Transmit strobe.
	input wire logic [6:0] tx_char,        // Transmit character.
	input wire logic       dialer_active,  // Dial card busy.
	input wire logic       dial_start,     // Dial pulse.
	input wire logic       hang_up         // Disconnect pulse.
);
	logic       acc;
	logic       ini_q;
	logic       pend_q;
	logic [1:0] op_q;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// An instruction is taken when it arrives while the adapter is free.
	assign acc = instr_valid && !io_busy_flag && !dialer_active;

	// Tracks the operation in progress and whether setup has completed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ini_q <= 1'b0;
			pend_q <= 1'b0;
			op_q <= 2'h0;
		end else if (acc) begin
			pend_q <= instr_char[5:0] == 6'h33;
			op_q <= instr_char[5:4];
		end else if (pend_q && mem_valid && output_request) begin
			ini_q <= 1'b1;
			pend_q <= 1'b0;
		end
	end

	status_fixed_a: assert property (status_valid |-> status_char[6:4] == 3'b010)
		else $error("status fixed bits wrong");
	flag_alone_a: assert property (status_valid && status_char[1] |-> status_char[2:0] == 3'b010)
		else $error("flag status carries other bits");
	busy_drop_a: assert property (status_valid |=> !io_busy_flag)
		else $error("busy still set after status");
	uninit_flag_a: assert property (acc && !ini_q && instr_char[5:0] != 6'h33
		|-> ##[1:3] status_valid && status_char[1])
		else $error("instruction before setup without flag");
	ctrl_bit_a: assert property (tx_valid && !op_q[0] |-> !tx_char[6])
		else $error("control code sent with top bit set");
	dial_pulse_a: assert property (acc && ini_q && instr_char[5:0] == 6'h31 |-> ##[1:4] dial_start)
		else $error("dialing not started");
	hang_pulse_a: assert property (acc && ini_q && instr_char[5:0] == 6'h32 |-> ##[1:4] hang_up)
		else $error("hang up not issued");
	dial_quiet_a: assert property (dialer_active [*4] ##0 (instr_valid && !io_busy_flag) |=> !io_busy_flag)
		else $error("instruction taken while dialing");

	init_c: cover property (acc && instr_char[5:0] == 6'h33);
	fault_c: cover property (status_valid && status_char[2]);
	hang_c: cover property (hang_up);
endmodule : instr_ctrl_checker

bind aca_instr_ctrl instr_ctrl_checker chk_u (.pclk, .presetn, .instr_valid, .instr_char, .mem_valid,
	.output_request, .io_busy_flag, .status_valid, .status_char, .tx_valid, .tx_char, .dialer_active,
	.dial_start, .hang_up);

/* verification/host_model.sv */
// Host processor model: issues select characters and feeds memory characters.
`timescale 1ns/100ps
module host_model (
	input  wire logic       pclk,           // Clock.
	input  wire logic       output_request, // Adapter wants characters.
	input  wire logic       tx_ready,       // Serializer can take one.
	output logic            instr_valid,    // Select strobe.
	output logic      [6:0] instr_char,     // Select character.
	output logic            mem_valid,      // Memory character strobe.
	output logic      [6:0] mem_char,       // Memory character.
	output logic            last_char_flag  // Count exhausted.
);
	logic [6:0] q[$];
	logic       fin = 1'b0;
	int         slow = 1;
	int         gap = 0;

	initial {instr_valid, instr_char, mem_valid, mem_char, last_char_flag} = '0;

	// Hands out queued characters while asked, spaced by slow cycles; idle data toggles.
	always @(posedge pclk) begin
		mem_valid <= 1'b0;
		mem_char <= ~mem_char;
		if (gap > 0) begin
			gap <= gap - 1;
		end else if (output_request && tx_ready && q.size() > 0) begin
			mem_valid <= 1'b1;
			mem_char <= q.pop_front();
			gap <= slow;
		end
		last_char_flag <= fin && (q.size() == 0);
	end

	// Sends one select character; f says the count ends with the queued data.
	task automatic issue(input logic [6:0] ch, input logic f);
		@(posedge pclk);
		instr_valid <= 1'b1;
		instr_char <= ch;
		fin <= f;
		@(posedge pclk);
		instr_valid <= 1'b0;
	endtask : issue
endmodule : host_model

/* verification/async_comm_adapter_instr_ctrl_tb.sv */
// Self-checking bench for the adapter instruction control.
`timescale 1ns/100ps
module async_comm_adapter_instr_ctrl_tb;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        instr_valid, mem_valid, last_char_flag, output_request, mem_wr_valid, io_busy_flag;
	logic        status_valid, tx_valid, tx_ready, rx_valid, rx_error, even_parity, modem_ready;
	logic        carrier_on, dialer_active, abandon_call_retry, reverse_channel, dial_start, hang_up;
	logic [6:0]  instr_char, mem_char, mem_wr_char, status_char, tx_char, rx_char, st;
	logic [6:0]  txs[$], got[$];
	logic [6:0]  ends[7] = '{7'h03, 7'h04, 7'h05, 7'h06, 7'h15, 7'h17, 7'h10};
	int          fails = 0, comparisons = 0, st_n = 0, nd = 0, nh = 0, c, sd = 0;

	always #4 pclk = ~pclk;

	aca_instr_ctrl #(.TIMEOUT_CYC(32'd200), .REVDROP_CYC(32'd50)) dut_u (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.instr_valid, .instr_char, .mem_valid, .mem_char, .last_char_flag, .output_request,
		.mem_wr_valid, .mem_wr_char, .io_busy_flag, .status_valid, .status_char, .tx_valid,
		.tx_char, .tx_ready, .rx_valid, .rx_char, .rx_error, .bit_tick(), .even_parity,
		.store_forward_mode(), .modem_ready, .carrier_on, .dialer_active, .abandon_call_retry,
		.reverse_channel, .dial_start, .hang_up);

	host_model host_u (.pclk, .output_request, .tx_ready, .instr_valid, .instr_char, .mem_valid,
		.mem_char, .last_char_flag);

	// Records what the adapter hands out.
	always @(posedge pclk) begin
		if (status_valid) st <= status_char;
		if (status_valid) st_n <= st_n + 1;
		if (tx_valid) txs.push_back(tx_char);
		if (mem_wr_valid) got.push_back(mem_wr_char);
		if (dial_start) nd <= nd + 1;
		if (hang_up) nh <= nh + 1;
	end

	// Counts a comparison and reports a mismatch.
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : cmp

	// One register access held until ready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// One received character; the line data changes once the strobe ends.
	task automatic rx(input logic [6:0] ch, input logic er);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_char <= ch;
		rx_error <= er;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_char <= ~ch;
		repeat (3) @(posedge pclk);
	endtask : rx

	// Waits, bounded, for a status not yet consumed, which may already have come, and counts the cycles.
	task automatic wst();
		c = 0;
		while (st_n == sd && c < 400) begin
			@(posedge pclk);
			c++;
		end
		cmp(32'(st_n != sd), 1);
		sd = st_n;
	endtask : wst

	task automatic done(input string s);
		$display("%0t test %s done", $time, s);
	endtask : done

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	// The tests need well under 20000 cycles.
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		{presetn, psel, penable, pwrite, rx_valid, rx_error, dialer_active, abandon_call_retry} = '0;
		{paddr, pwdata, rx_char} = '0;
		{tx_ready, modem_ready, carrier_on} = 3'b111;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		host_u.issue(7'h41, 1'b0);
		wst();
		cmp(st, 7'h22);
		apb(1'b0, 8'h0C, 32'h0);
		cmp(e, 1'b1);
		host_u.q.push_back(7'h14);
		host_u.issue(7'h73, 1'b0);
		wst();
		apb(1'b0, 8'h04, 32'h0);
		cmp(r[7:0], 8'h94);
		cmp(even_parity, 1'b1);
		done("setup");
		// Read that sends two control codes first, then receives up to each ending code.
		txs.delete();
		host_u.q = '{7'h41, 7'h52};
		host_u.issue(7'h42, 1'b0);
		repeat (12) @(posedge pclk);
		cmp(txs.size(), 2);
		cmp(txs[1], 7'h12);
		cmp(output_request, 1'b0);
		foreach (ends[i]) begin
			if (i > 0) host_u.issue(7'h40, 1'b0);
			got.delete();
			rx(7'h48, 1'b0);
			rx(ends[i], 1'b0);
			if (ends[i] == 7'h10) begin
				cmp(io_busy_flag, 1'b1);
				rx(7'h41, 1'b0);
			end
			wst();
			cmp(st, 7'h20);
			cmp(got[0], 7'h48);
		end
		// Count exhausted with a bad character: only FLAG.
		host_u.issue(7'h40, 1'b0);
		rx(7'h41, 1'b1);
		host_u.fin <= 1'b1;
		wst();
		cmp(st, 7'h22);
		// Received data restarts the idle timer; silence then ends in FAULT.
		host_u.issue(7'h40, 1'b0);
		repeat (150) @(posedge pclk);
		rx(7'h41, 1'b0);
		repeat (150) @(posedge pclk);
		cmp(io_busy_flag, 1'b1);
		wst();
		cmp(st, 7'h24);
		cmp(32'(c > 40 && c < 60), 1);
		done("read");
		// Read-control keeps the first character as address and sends the rest.
		txs.delete();
		got.delete();
		host_u.q = '{7'h53, 7'h41};
		host_u.issue(7'h62, 1'b0);
		repeat (12) @(posedge pclk);
		cmp(txs.size(), 1);
		cmp(txs[0], 7'h01);
		rx(7'h58, 1'b0);
		rx(7'h53, 1'b0);
		rx(7'h03, 1'b0);
		wst();
		cmp(got[0], 7'h53);
		got.delete();
		host_u.issue(7'h60, 1'b0);
		rx(7'h53, 1'b0);
		wst();
		cmp(st, 7'h24);
		cmp(got.size(), 0);
		done("read control");
		// Slow host write; then a dead modem.
		txs.delete();
		host_u.slow = 4;
		host_u.q = '{7'h41, 7'h42, 7'h43};
		host_u.issue(7'h51, 1'b1);
		wst();
		cmp(txs.size(), 3);
		cmp(txs[0], 7'h01);
		cmp(txs[2], 7'h43);
		modem_ready <= 1'b0;
		host_u.issue(7'h50, 1'b0);
		wst();
		cmp(st, 7'h24);
		modem_ready <= 1'b1;
		done("write");
		// Dial abandoned, hang up, reverse channel hold, busy dial card.
		host_u.issue(7'h71, 1'b0);
		abandon_call_retry <= 1'b1;
		repeat (5) @(posedge pclk);
		abandon_call_retry <= 1'b0;
		wst();
		cmp(st, 7'h21);
		host_u.issue(7'h72, 1'b0);
		wst();
		cmp(nh, 1);
		host_u.issue(7'h75, 1'b0);
		wst();
		repeat (20) @(posedge pclk);
		cmp(reverse_channel, 1'b0);
		dialer_active <= 1'b1;
		repeat (4) @(posedge pclk);
		host_u.issue(7'h40, 1'b0);
		repeat (4) @(posedge pclk);
		cmp(io_busy_flag, 1'b0);
		cmp(reverse_channel, 1'b0);
		dialer_active <= 1'b0;
		done("control");
		// Armed carrier-drop hardware, persistence, then I/O reset.
		repeat (4) @(posedge pclk);
		host_u.q.push_back(7'h54);
		host_u.issue(7'h73, 1'b0);
		wst();
		carrier_on <= 1'b0;
		repeat (15) @(posedge pclk);
		carrier_on <= 1'b1;
		cmp(reverse_channel, 1'b0);
		repeat (60) @(posedge pclk);
		cmp(reverse_channel, 1'b1);
		apb(1'b0, 8'h04, 32'h0);
		cmp(r[7:0], 8'hD4);
		// Store-forward read with a bad character: status char to memory before status.
		host_u.q.push_back(7'h0C);
		host_u.issue(7'h73, 1'b0);
		wst();
		got.delete();
		host_u.issue(7'h40, 1'b0);
		rx(7'h41, 1'b1);
		rx(7'h03, 1'b0);
		wst();
		cmp(got[2], 7'h0C);
		cmp(st, 7'h21);
		apb(1'b1, 8'h00, 32'h1);
		host_u.issue(7'h50, 1'b0);
		wst();
		cmp(st, 7'h22);
		done("reinit");
		wrap_up();
	end
endmodule : async_comm_adapter_instr_ctrl_tb
